// ### verilog/firhe_pkg.sv
package firhe_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PAUSE_EN    = 8'hAA;
	localparam logic [7:0] OP_LEGACY_ID_A = 8'h90;
	localparam logic [7:0] OP_LEGACY_ID_B = 8'hAB;
	localparam logic [7:0] OP_STD_ID      = 8'h9F;

	// ----------------------------------------------------------------
	// Framing counts
	// ----------------------------------------------------------------
	localparam logic [2:0] BIT_FIRST      = 3'h0;
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
	localparam logic [1:0] STD_BYTE_FIRST = 2'h0;
	localparam logic [1:0] STD_BYTE_MEM   = 2'h1;
	localparam logic [1:0] STD_BYTE_LAST  = 2'h2;

	// Legacy select: 0 = maker code, 1 = part code
	localparam logic       SEL_MAKER      = 1'b0;
	localparam logic       SEL_PART       = 1'b1;

	// ----------------------------------------------------------------
	// Identity defaults (values arbitrary)
	// ----------------------------------------------------------------
	localparam logic [7:0] MAKER_CODE_DEF = 8'h5A;
	localparam logic [7:0] MEM_TYPE_DEF   = 8'h26;
	localparam logic [7:0] PART_CODE_DEF  = 8'h3C;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR   = 3'b001,
		ST_PAUSE  = 3'b010,
		ST_LEGACY = 3'b011,
		ST_STD    = 3'b100,
		ST_IGNORE = 3'b101
	} firhe_state_t;

	typedef struct packed {
		logic data;
		logic oe;
	} firhe_sdo_t;

endpackage

// ### verilog/firhe_sync.sv
module firhe_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic din,
	output logic      dout
);

	logic meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_r <= RESET_VAL;
			dout   <= RESET_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule // firhe_sync

// ### verilog/firhe_core.sv
// Summary of operation
// R1 - Opcode AAH switches the shared reset/pause pin into its pause role.
// R2 - Host keeps chip enable low through the whole pause-enable opcode.
// R3 - Pause enable takes effect only when chip enable rises after the full opcode.
// R4 - Opcode 90H or ABH, then a 24-bit address MSB first, starts legacy ID read.
// R5 - Legacy address 0 selects maker code, address 1 selects part code.
// R6 - Legacy read keeps alternating maker and part code each byte until chip enable rises.
// R7 - Chip enable rising ends legacy read and returns the port to idle.
// R8 - Opcode 9FH takes no address; a 24-bit identifier follows, maker code first.
// R9 - Standard ID bytes: maker code, memory-type byte, capacity byte.
// R10 - Chip enable rising stops output driving at once, even mid-byte.
// R11 - Each output bit changes on the falling serial clock edge.
// R12 - All bytes are eight bits, most significant bit first.
// R13 - Inputs sampled on rising clock edge; clock idles low or high (modes 0, 3).
module firhe_core #(
	parameter logic [7:0] MAKER_CODE = firhe_pkg::MAKER_CODE_DEF,
	parameter logic [7:0] MEM_TYPE   = firhe_pkg::MEM_TYPE_DEF,
	parameter logic [7:0] PART_CODE  = firhe_pkg::PART_CODE_DEF
) (
	input  wire logic           sys_clk,
	input  wire logic           srst,
	input  wire logic           spiClk,
	input  wire logic           ceN,
	input  wire logic           sdi,
	output firhe_pkg::firhe_sdo_t sdoPin,
	output logic                pauseRoleEn
);

	// ----------------------------------------------------------------
	// Link domain: receive side
	// ----------------------------------------------------------------
	firhe_pkg::firhe_state_t state_r;
	firhe_pkg::firhe_state_t state_nxt;
	logic [2:0]              bitCnt_r;
	logic [6:0]              rxShift_r;
	logic [1:0]              byteCnt_r;
	logic [1:0]              byteCnt_nxt;
	logic                    legacySel_r;
	logic                    legacySel_nxt;
	logic                    pauseSeen_r;

	wire       [7:0] rxByte     = {rxShift_r, sdi};                       // R12
	wire             byteDone   = (bitCnt_r == firhe_pkg::BIT_LAST);      // R12
	wire       [2:0] bitCntInc  = bitCnt_r + 3'h1;
	wire       [1:0] byteCntInc = byteCnt_r + 2'h1;
	wire             isLegacyOp = (rxByte == firhe_pkg::OP_LEGACY_ID_A) ||
	                              (rxByte == firhe_pkg::OP_LEGACY_ID_B);  // R4
	wire             isStdOp    = (rxByte == firhe_pkg::OP_STD_ID);       // R8
	wire             isPauseOp  = (rxByte == firhe_pkg::OP_PAUSE_EN);     // R1
	wire             addrDone   = byteDone && (byteCnt_r == firhe_pkg::ADDR_BYTE_LAST);
	wire             stdWrap    = byteDone && (byteCnt_r == firhe_pkg::STD_BYTE_LAST);

	// ----------------------------------------------------------------
	// Link domain: command decode
	// ----------------------------------------------------------------
	// Only the last address bit is decoded; higher address bits of the legacy
	// read are shifted in and dropped, which keeps the decode to one bit.
	always_comb begin
		state_nxt     = state_r;
		byteCnt_nxt   = byteCnt_r;
		legacySel_nxt = legacySel_r;
		unique case (state_r)
			firhe_pkg::ST_OPCODE: begin
				if (byteDone) begin
					byteCnt_nxt = firhe_pkg::STD_BYTE_FIRST;
					if (isLegacyOp) begin
						state_nxt = firhe_pkg::ST_ADDR;          // R4
					end else if (isStdOp) begin
						state_nxt = firhe_pkg::ST_STD;           // R8
					end else if (isPauseOp) begin
						state_nxt = firhe_pkg::ST_PAUSE;         // R1
					end else begin
						state_nxt = firhe_pkg::ST_IGNORE;
					end
				end
			end
			firhe_pkg::ST_ADDR: begin
				if (byteDone) begin
					byteCnt_nxt = byteCntInc;
				end
				// Last address bit is the byte select
				if (addrDone) begin
					legacySel_nxt = sdi;                         // R5
					state_nxt     = firhe_pkg::ST_LEGACY;
				end
			end
			firhe_pkg::ST_PAUSE: begin
				// Any clocking past the opcode spoils the command
				state_nxt = firhe_pkg::ST_IGNORE;               // R3
			end
			firhe_pkg::ST_LEGACY: begin
				if (byteDone) begin
					legacySel_nxt = ~legacySel_r;                // R6
				end
			end
			firhe_pkg::ST_STD: begin
				if (stdWrap) begin
					byteCnt_nxt = firhe_pkg::STD_BYTE_FIRST;
				end else if (byteDone) begin
					byteCnt_nxt = byteCntInc;                    // R9
				end
			end
			firhe_pkg::ST_IGNORE: begin
				state_nxt = firhe_pkg::ST_IGNORE;
			end
			default: begin
				state_nxt = firhe_pkg::ST_IGNORE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Link domain: frame registers
	// ----------------------------------------------------------------
	// Chip enable high holds the frame logic idle: every frame starts clean
	always_ff @(posedge spiClk or posedge ceN) begin
		if (ceN) begin                                           // R7
			state_r     <= firhe_pkg::ST_OPCODE;
			bitCnt_r    <= firhe_pkg::BIT_FIRST;
			rxShift_r   <= 7'h00;
			byteCnt_r   <= 2'h0;
			legacySel_r <= firhe_pkg::SEL_MAKER;
		end else begin                                           // R13
			state_r     <= state_nxt;
			bitCnt_r    <= bitCntInc;
			rxShift_r   <= rxByte[6:0];
			byteCnt_r   <= byteCnt_nxt;
			legacySel_r <= legacySel_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: pause-enable capture
	// ----------------------------------------------------------------
	// Survives chip enable rising so the system side can see it; cleared by
	// the first clock edge of the next frame or by any extra bit.
	always_ff @(posedge spiClk or posedge srst) begin
		if (srst)
			pauseSeen_r <= 1'b0;
		else
			pauseSeen_r <= (state_r == firhe_pkg::ST_OPCODE) && byteDone && isPauseOp; // R2
	end

	// ----------------------------------------------------------------
	// Link domain: transmit side
	// ----------------------------------------------------------------
	wire             outActive = (state_r == firhe_pkg::ST_LEGACY) ||
	                             (state_r == firhe_pkg::ST_STD);
	wire       [7:0] legacyByte = (legacySel_r == firhe_pkg::SEL_PART) ? PART_CODE : MAKER_CODE; // R5
	wire       [7:0] stdByte    = (byteCnt_r == firhe_pkg::STD_BYTE_FIRST) ? MAKER_CODE :
	                              (byteCnt_r == firhe_pkg::STD_BYTE_MEM)   ? MEM_TYPE   :
	                              PART_CODE;                                        // R9
	wire       [7:0] txByte     = (state_r == firhe_pkg::ST_STD) ? stdByte : legacyByte;
	wire       [7:0] txShifted  = txByte << bitCnt_r;                               // R12

	// Async clear on chip enable drops the driver mid-byte
	always_ff @(negedge spiClk or posedge ceN) begin
		if (ceN) begin                                           // R10
			sdoPin <= '0;
		end else begin                                           // R11
			sdoPin.oe   <= outActive;                            // R8
			sdoPin.data <= txShifted[7];
		end
	end

	// ----------------------------------------------------------------
	// System domain: pause-role commit
	// ----------------------------------------------------------------
	logic ceSync;
	logic pauseSync;
	logic ceDly1_r;
	logic ceDly2_r;

	firhe_sync #(
		.RESET_VAL (1'b1)
	) u_ceSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.din     (ceN),
		.dout    (ceSync)
	);

	firhe_sync #(
		.RESET_VAL (1'b0)
	) u_pauseSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.din     (pauseSeen_r),
		.dout    (pauseSync)
	);

	// ----------------------------------------------------------------
	// System domain: commit decision
	// ----------------------------------------------------------------
	// Extra stage on chip enable so the pause flag has settled first;
	// costs one cycle of latency but avoids racing the two synchronisers
	wire ceRise = ceDly1_r && !ceDly2_r;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ceDly1_r    <= 1'b1;
			ceDly2_r    <= 1'b1;
			pauseRoleEn <= 1'b0;
		end else begin
			ceDly1_r <= ceSync;
			ceDly2_r <= ceDly1_r;
			// Sticky until reset; the pin never returns to reset role on its own
			if (ceRise && pauseSync)
				pauseRoleEn <= 1'b1;                             // R3
		end
	end

endmodule // firhe_core

// ### dv/firhe_core_props.sv
module firhe_core_props #(
	parameter logic [7:0] MAKER_CODE = firhe_pkg::MAKER_CODE_DEF
) (
	input wire logic             sys_clk,
	input wire logic             srst,
	input wire logic             spiClk,
	input wire logic             ceN,
	input wire logic             sdi,
	input firhe_pkg::firhe_sdo_t sdoPin,
	input wire logic             pauseRoleEn
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Frame tracker, cleared while deselected
	// ------
	logic [5:0] edgeCnt;
	logic [7:0] opSh;
	always_ff @(posedge spiClk or posedge ceN) begin
		if (ceN) begin
			edgeCnt <= 6'h00;
			opSh    <= 8'h00;
		end else begin
			if (edgeCnt != 6'h3F) edgeCnt <= edgeCnt + 6'h01;
			if (edgeCnt < 6'h08) opSh <= {opSh[6:0], sdi};
		end
	end
	AST_OE_CE: assert property (@(posedge sys_clk) disable iff (srst) ceN |-> !sdoPin.oe)
		else $error("output on while deselected");
	AST_PAUSE_HOLD: assert property (@(posedge sys_clk) disable iff (srst) pauseRoleEn |=> pauseRoleEn)
		else $error("pause role dropped");
	AST_PAUSE_CLR: assert property (@(posedge sys_clk) srst |=> !pauseRoleEn)
		else $error("pause role kept over reset");
	AST_PAUSE_CE: assert property (@(posedge sys_clk) disable iff (srst) $rose(pauseRoleEn) |-> ceN && $past(ceN, 2))
		else $error("pause role set inside frame");
	AST_DATA_HOLD: assert property (@(posedge sys_clk) disable iff (srst || ceN)
		spiClk && $past(spiClk) |-> $stable(sdoPin.data))
		else $error("data moved while clock high");
	AST_OE_EARLY: assert property (@(posedge spiClk) disable iff (ceN) edgeCnt < 6'h08 |-> !sdoPin.oe)
		else $error("output during opcode");
	AST_STD_OE: assert property (@(posedge spiClk) disable iff (ceN) edgeCnt == 6'h08 && opSh == firhe_pkg::OP_STD_ID
		|-> sdoPin.oe && sdoPin.data == MAKER_CODE[7])
		else $error("ident reply missing");
	AST_LEG_OE: assert property (@(posedge spiClk) disable iff (ceN) edgeCnt < 6'h20 && opSh != firhe_pkg::OP_STD_ID
		|-> !sdoPin.oe)
		else $error("output before address done");
endmodule // firhe_core_props
bind firhe_core firhe_core_props #(.MAKER_CODE(MAKER_CODE)) props_u (.sys_clk(sys_clk), .srst(srst), .spiClk(spiClk),
	.ceN(ceN), .sdi(sdi), .sdoPin(sdoPin), .pauseRoleEn(pauseRoleEn));

// ### dv/firhe_spi_host.sv
module firhe_spi_host (
	output logic                 spiClk,
	output logic                 ceN,
	output logic                 sdi,
	input firhe_pkg::firhe_sdo_t sdoPin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Host frames; clock idles still between them
	// ------
	initial begin
		spiClk = 1'b0;
		ceN = 1'b1;
		sdi = 1'b0;
	end
	task automatic frame(input logic [31:0] tx, input int nOut, input int nIn, input logic m3,
		output logic [31:0] rx, output logic oeOk);
		int i;
		rx = 32'h0;
		oeOk = 1'b1;
		#7 spiClk <= m3;
		#40 ceN <= 1'b0;
		for (i = 0; i < nOut + nIn; i++) begin
			spiClk <= 1'b0;
			sdi <= (i < nOut) ? tx[31 - i] : ~sdi;
			#40;
			if (i >= nOut) begin
				rx = {rx[30:0], sdoPin.data};
				oeOk &= sdoPin.oe;
			end
			spiClk <= 1'b1;
			#40;
		end
		spiClk <= m3;
		#20 ceN <= 1'b1;
		sdi <= ~sdi;
	endtask
endmodule // firhe_spi_host

// ### dv/flash_id_read_hold_enable_tb.sv
module flash_id_read_hold_enable_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] M = firhe_pkg::MAKER_CODE_DEF;
	localparam logic [7:0] T = firhe_pkg::MEM_TYPE_DEF;
	localparam logic [7:0] P = firhe_pkg::PART_CODE_DEF;
	localparam logic [31:0] STD = {firhe_pkg::OP_STD_ID, 24'h000000};
	logic                   sysClk = 1'b0;
	logic                   srst = 1'b1;
	logic                   spiClk;
	logic                   ceN;
	logic                   sdi;
	logic                   pauseRoleEn;
	firhe_pkg::firhe_sdo_t  sdoPin;
	int                     nErrors = 0;
	int                     samplesChecked = 0;
	// ------
	// Harness
	// ------
	always #10 sysClk = ~sysClk;
	firhe_core dut_u (.sys_clk(sysClk), .srst(srst), .spiClk(spiClk), .ceN(ceN), .sdi(sdi), .sdoPin(sdoPin),
		.pauseRoleEn(pauseRoleEn));
	firhe_spi_host host_u (.spiClk(spiClk), .ceN(ceN), .sdi(sdi), .sdoPin(sdoPin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic testDone();
		$display("errors %0d checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic runRead(input logic [31:0] tx, input int nOut, input int nIn, input logic m3, input logic [31:0] exp);
		logic [31:0] rx;
		logic ok;
		host_u.frame(tx, nOut, nIn, m3, rx, ok);
		#1;
		check({31'h0, sdoPin.oe}, 32'h0);
		check({31'h0, ok}, 32'h1);
		check(rx, exp);
		@(posedge sysClk);
	endtask
	task automatic testStdId();
		runRead(STD, 8, 32, 1'b0, {M, T, P, M});
		runRead(STD, 8, 32, 1'b1, {M, T, P, M});
	endtask
	task automatic testLegacyId();
		runRead({firhe_pkg::OP_LEGACY_ID_A, 24'h000000}, 32, 32, 1'b0, {M, P, M, P});
		runRead({firhe_pkg::OP_LEGACY_ID_B, 24'h000001}, 32, 24, 1'b1, {8'h00, P, M, P});
	endtask
	task automatic testAbort();
		logic [31:0] rx;
		logic ok;
		runRead(STD, 8, 12, 1'b0, {20'h00000, M, T[7:4]});
		host_u.frame({8'h03, 24'h000000}, 8, 16, 1'b0, rx, ok);
		#1 check({31'h0, ok}, 32'h0);
		@(posedge sysClk);
	endtask
	task automatic testPause();
		logic [31:0] rx;
		logic ok;
		int i;
		host_u.frame({firhe_pkg::OP_PAUSE_EN, 24'h000000}, 7, 0, 1'b0, rx, ok);
		@(posedge sysClk);
		host_u.frame({firhe_pkg::OP_PAUSE_EN, 24'h000000}, 9, 0, 1'b1, rx, ok);
		repeat (8) @(posedge sysClk);
		check({31'h0, pauseRoleEn}, 32'h0);
		host_u.frame({firhe_pkg::OP_PAUSE_EN, 24'h000000}, 8, 0, 1'b0, rx, ok);
		for (i = 0; i < 10 && pauseRoleEn !== 1'b1; i++) @(posedge sysClk) #1;
		check({31'h0, pauseRoleEn}, 32'h1);
		check({31'h0, i >= 4 && i <= 5}, 32'h1);
		if (i == 10) testDone();
		@(posedge sysClk) srst <= 1'b1;
		repeat (3) @(posedge sysClk);
		srst <= 1'b0;
		#1 check({31'h0, pauseRoleEn}, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge sysClk);
		srst <= 1'b0;
		testStdId();
		testLegacyId();
		testAbort();
		testPause();
		testDone();
	end
endmodule // flash_id_read_hold_enable_tb
